// *** pkg/psc_pkg.sv ***
// shared constants and carrier types of the program sequencer
package psc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PSC_PC_WIDTH = 10;
  localparam int PSC_LEN_WIDTH = 2;
  localparam int PSC_DM_ADDR_WIDTH = 4;
  localparam int PSC_DM_DATA_WIDTH = 8;
  localparam int PSC_DM_DEPTH = 16;
  localparam int PSC_RET_LOW_WIDTH = 8;
  localparam int PSC_RET_HIGH_WIDTH = 2;

  // ----------------------------------------------------------------
  // reset values and fixed locations
  // ----------------------------------------------------------------
  localparam logic [PSC_PC_WIDTH-1:0] PSC_PC_RESET = 10'h000;
  localparam logic PSC_SP_RESET = 1'b0;
  localparam logic PSC_SP_ACTIVE = 1'b1;
  // the last data-memory word doubles as the low return-address byte
  localparam logic [PSC_DM_ADDR_WIDTH-1:0] PSC_SHARED_WORD = 4'hf;
  localparam logic [PSC_LEN_WIDTH-1:0] PSC_LEN_ZERO = 2'h0;

  // ----------------------------------------------------------------
  // operations presented by the instruction decoder
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSC_OP_STEP,
    PSC_OP_BRANCH_UNCONDITIONAL,
    PSC_OP_BRANCH_IF_CARRY_SET,
    PSC_OP_BRANCH_IF_CARRY_CLEAR,
    PSC_OP_BRANCH_IF_FLAG_SET,
    PSC_OP_BRANCH_IF_FLAG_CLEAR,
    PSC_OP_CALL,
    PSC_OP_SUBROUTINE_EXIT
  } psc_kind_type;

  // one executed instruction as seen by the sequencer
  typedef struct packed {
    psc_kind_type kind;
    logic [PSC_LEN_WIDTH-1:0] length;
    logic [PSC_PC_WIDTH-1:0] target;
  } psc_op_type;

  // one ordinary data-memory access from the core
  typedef struct packed {
    logic write;
    logic [PSC_DM_ADDR_WIDTH-1:0] addr;
    logic [PSC_DM_DATA_WIDTH-1:0] wdata;
  } psc_dm_req_type;

endpackage : psc_pkg

// *** verilog/psc_data_mem.sv ***
// data memory of sixteen byte words with registered read data
`timescale 1ns/100ps

module psc_data_mem (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [psc_pkg::PSC_DM_ADDR_WIDTH-1:0] addr_in,
  input wire logic [psc_pkg::PSC_DM_DATA_WIDTH-1:0] wdata_in,
  output logic [psc_pkg::PSC_DM_DATA_WIDTH-1:0] rdata_out
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // contents survive reset, so the array has no reset branch
  logic [psc_pkg::PSC_DM_DATA_WIDTH-1:0] mem_reg [psc_pkg::PSC_DM_DEPTH];
  logic [psc_pkg::PSC_DM_DATA_WIDTH-1:0] rdata_reg;

  // write port
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_reg[addr_in] <= wdata_in;
    end
  end

  // read port, old data on a same-cycle write
  always_ff @(posedge clk_in) begin
    rdata_reg <= mem_reg[addr_in];
  end

  assign rdata_out = rdata_reg;

endmodule : psc_data_mem

// *** verilog/psc_sequencer.sv ***
// program counter and one-level call stack of the 4-bit core
`timescale 1ns/100ps


// things a user must know
// - a data write to the shared word changes the low return byte only,
//   so a later return lands at the upper bits joined to the new byte
// - a return stalls the instruction port for one cycle while the
//   shared word is read back through the registered memory port
// - a stack fault costs one idle cycle before fetching from zero
// - a core data access waits one cycle when the stack owns the port
// - the upper return bits hold no defined value until the first call
// - length zero leaves the counter where it is
// - carry and flag are taken as they stand in the accepting cycle

module psc_sequencer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic op_valid_in,
  input wire psc_pkg::psc_op_type op_in,
  input wire logic carry_in,
  input wire logic flag_in,
  output logic op_ready_out,
  output logic [psc_pkg::PSC_PC_WIDTH-1:0] pc_out,
  output logic stack_ptr_out,
  output logic sys_reset_out,
  input wire logic dm_valid_in,
  input wire psc_pkg::psc_dm_req_type dm_req_in,
  output logic dm_ready_out,
  output logic [psc_pkg::PSC_DM_DATA_WIDTH-1:0] dm_rdata_out,
  output logic dm_rvalid_out
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // address of the instruction that follows the one being executed
  function automatic logic [psc_pkg::PSC_PC_WIDTH-1:0] pc_advance(
    input logic [psc_pkg::PSC_PC_WIDTH-1:0] pc,
    input logic [psc_pkg::PSC_LEN_WIDTH-1:0] len
  );
    logic [psc_pkg::PSC_PC_WIDTH-1:0] len_wide;
    len_wide = {8'h00, len};
    return pc + len_wide;
  endfunction : pc_advance

  // true when an operation is one of the five branch kinds
  function automatic logic is_branch(input psc_pkg::psc_kind_type kind);
    return (kind == psc_pkg::PSC_OP_BRANCH_UNCONDITIONAL) ||
           (kind == psc_pkg::PSC_OP_BRANCH_IF_CARRY_SET) ||
           (kind == psc_pkg::PSC_OP_BRANCH_IF_CARRY_CLEAR) ||
           (kind == psc_pkg::PSC_OP_BRANCH_IF_FLAG_SET) ||
           (kind == psc_pkg::PSC_OP_BRANCH_IF_FLAG_CLEAR);
  endfunction : is_branch

  // branch condition against the current carry and status flag
  function automatic logic branch_taken(
    input psc_pkg::psc_kind_type kind,
    input logic carry,
    input logic flag
  );
    logic taken;
    taken = 1'b0;
    case (kind)
      psc_pkg::PSC_OP_BRANCH_UNCONDITIONAL: taken = 1'b1;
      psc_pkg::PSC_OP_BRANCH_IF_CARRY_SET: taken = carry;
      psc_pkg::PSC_OP_BRANCH_IF_CARRY_CLEAR: taken = !carry;
      psc_pkg::PSC_OP_BRANCH_IF_FLAG_SET: taken = flag;
      psc_pkg::PSC_OP_BRANCH_IF_FLAG_CLEAR: taken = !flag;
      default: taken = 1'b0;
    endcase
    return taken;
  endfunction : branch_taken

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------

  // run takes operations, return waits on the shared word,
  // fault is the one cycle of internal system reset;
  // the enum stays local, as nothing outside sees the state
  typedef enum logic [1:0] {
    PSC_ST_RUN,
    PSC_ST_RETURN,
    PSC_ST_FAULT
  } psc_state_type;

  psc_state_type state_reg;
  psc_state_type state_next;
  logic [psc_pkg::PSC_PC_WIDTH-1:0] pc_reg;
  logic [psc_pkg::PSC_PC_WIDTH-1:0] pc_next;
  logic sp_reg;
  logic sp_next;
  logic [psc_pkg::PSC_RET_HIGH_WIDTH-1:0] ret_high_reg;
  logic [psc_pkg::PSC_RET_HIGH_WIDTH-1:0] ret_high_next;
  logic sys_reset_reg;
  logic sys_reset_next;
  logic dm_rvalid_reg;

  // ----------------------------------------------------------------
  // operation decode
  // ----------------------------------------------------------------

  wire logic accept;
  wire logic op_is_step;
  wire logic op_is_branch;
  wire logic op_is_call;
  wire logic op_is_exit;
  wire logic take_branch;
  wire logic overflow;
  wire logic underflow;
  wire logic call_ok;
  wire logic exit_ok;
  wire logic stack_fault;
  wire logic [psc_pkg::PSC_PC_WIDTH-1:0] pc_seq;
  wire logic [psc_pkg::PSC_PC_WIDTH-1:0] ret_addr;

  // operations are taken only while running; return and fault stall
  assign op_ready_out = (state_reg == PSC_ST_RUN);
  // no operation is taken while reset is held, else a call presented during
  // reset would overwrite the return address that reset must keep
  assign accept = op_valid_in && op_ready_out && !rst_in;

  assign op_is_step = (op_in.kind == psc_pkg::PSC_OP_STEP);
  assign op_is_branch = is_branch(op_in.kind);
  assign op_is_call = (op_in.kind == psc_pkg::PSC_OP_CALL);
  assign op_is_exit = (op_in.kind == psc_pkg::PSC_OP_SUBROUTINE_EXIT);

  assign take_branch = op_is_branch && branch_taken(op_in.kind, carry_in, flag_in);

  assign pc_seq = pc_advance(pc_reg, op_in.length);

  assign overflow = accept && op_is_call && (sp_reg == psc_pkg::PSC_SP_ACTIVE);
  assign underflow = accept && op_is_exit && (sp_reg == psc_pkg::PSC_SP_RESET);

  assign call_ok = accept && op_is_call && !overflow;
  assign exit_ok = accept && op_is_exit && !underflow;

  // either fault leads to the same internal reset
  assign stack_fault = overflow || underflow;

  // the address saved by a call is the one after the call
  assign ret_addr = pc_seq;

  // ----------------------------------------------------------------
  // shared data-memory port
  // ----------------------------------------------------------------

  wire logic seq_uses_mem;
  wire logic dm_accept;
  wire logic mem_we;
  wire logic [psc_pkg::PSC_DM_ADDR_WIDTH-1:0] mem_addr;
  wire logic [psc_pkg::PSC_DM_DATA_WIDTH-1:0] mem_wdata;
  wire logic [psc_pkg::PSC_DM_DATA_WIDTH-1:0] mem_rdata;

  // the stack owns the port on call and return; a core access
  // waits one cycle then, which costs little and avoids a collision
  assign seq_uses_mem = call_ok || exit_ok;
  assign dm_ready_out = !seq_uses_mem;
  assign dm_accept = dm_valid_in && dm_ready_out;

  // low return byte goes to the last word
  // same word also serves plain data
  // a faulting call writes nothing, so the old return byte survives
  assign mem_we = call_ok || (dm_accept && dm_req_in.write);
  assign mem_addr = seq_uses_mem ? psc_pkg::PSC_SHARED_WORD : dm_req_in.addr;
  assign mem_wdata = call_ok ? ret_addr[psc_pkg::PSC_RET_LOW_WIDTH-1:0] : dm_req_in.wdata;

  // byte-wide data memory, read data registered inside
  psc_data_mem u_data_mem (
    .clk_in(clk_in),
    .we_in(mem_we),
    .addr_in(mem_addr),
    .wdata_in(mem_wdata),
    .rdata_out(mem_rdata)
  );

  wire logic core_read;
  wire logic [psc_pkg::PSC_PC_WIDTH-1:0] restore_addr;

  // read data for the core come straight from the memory register
  assign dm_rdata_out = mem_rdata;
  assign dm_rvalid_out = dm_rvalid_reg;
  assign core_read = dm_accept && !dm_req_in.write;

  // return address rebuilt from own upper bits and the shared word
  // the word was read at the edge that took the return
  assign restore_addr = {ret_high_reg, mem_rdata};

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------

  // one decision per cycle for counter, pointer and state;
  // run -> return -> run after a good return,
  // run -> fault -> run after a stack fault,
  // every other operation stays in run
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    sp_next = sp_reg;
    ret_high_next = ret_high_reg;
    sys_reset_next = 1'b0;
    case (state_reg)
      PSC_ST_RUN: begin
        if (stack_fault) begin
          state_next = PSC_ST_FAULT;
          sys_reset_next = 1'b1;
          pc_next = psc_pkg::PSC_PC_RESET;
          sp_next = psc_pkg::PSC_SP_RESET;
        end else if (call_ok) begin
          ret_high_next = ret_addr[psc_pkg::PSC_PC_WIDTH-1:psc_pkg::PSC_RET_LOW_WIDTH];
          sp_next = psc_pkg::PSC_SP_ACTIVE;
          pc_next = op_in.target;
        end else if (exit_ok) begin
          sp_next = psc_pkg::PSC_SP_RESET;
          state_next = PSC_ST_RETURN;
        end else if (accept && take_branch) begin
          pc_next = op_in.target;
        end else if (accept && (op_is_step || op_is_branch)) begin
          pc_next = pc_seq;
        end
      end
      PSC_ST_RETURN: begin
        pc_next = restore_addr;
        state_next = PSC_ST_RUN;
      end
      PSC_ST_FAULT: begin
        // counter and pointer already forced; just resume
        state_next = PSC_ST_RUN;
      end
      default: begin
        state_next = PSC_ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------

  // state back to run on reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= PSC_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pc_reg <= psc_pkg::PSC_PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // one bit marks a live return address
  // no other path writes the pointer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sp_reg <= psc_pkg::PSC_SP_RESET;
    end else begin
      sp_reg <= sp_next;
    end
  end

  // internal reset lasts one cycle; an outside reset clears it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sys_reset_reg <= 1'b0;
    end else begin
      sys_reset_reg <= sys_reset_next;
    end
  end

  // upper return bits keep their value through reset
  // plain data writes never touch the upper bits
  // no reset branch on purpose: reset must not lose a pending return
  always_ff @(posedge clk_in) begin
    ret_high_reg <= ret_high_next;
  end

  // a core read is answered one cycle after it is taken
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dm_rvalid_reg <= 1'b0;
    end else begin
      dm_rvalid_reg <= core_read;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // counter shown as the next fetch address
  // all three come straight from flip-flops, so the core sees no glitch
  assign pc_out = pc_reg;
  assign stack_ptr_out = sp_reg;
  assign sys_reset_out = sys_reset_reg;

endmodule : psc_sequencer

// *** tb/psc_sequencer_monitor.sv ***
// port assertions of the program sequencer
`timescale 1ns/100ps

module psc_sequencer_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic op_valid_in,
  input wire psc_pkg::psc_op_type op_in,
  input wire logic carry_in,
  input wire logic flag_in,
  input wire logic op_ready_out,
  input wire logic [psc_pkg::PSC_PC_WIDTH-1:0] pc_out,
  input wire logic stack_ptr_out,
  input wire logic sys_reset_out,
  input wire logic dm_valid_in,
  input wire psc_pkg::psc_dm_req_type dm_req_in,
  input wire logic dm_ready_out,
  input wire logic [psc_pkg::PSC_DM_DATA_WIDTH-1:0] dm_rdata_out,
  input wire logic dm_rvalid_out
);
  // decoded events of the accepted instruction
  wire psc_pkg::psc_kind_type k = op_in.kind;
  wire take = op_valid_in && op_ready_out;
  wire is_call = take && k == psc_pkg::PSC_OP_CALL;
  wire is_ret = take && k == psc_pkg::PSC_OP_SUBROUTINE_EXIT;
  wire good = (is_call && !stack_ptr_out) || (is_ret && stack_ptr_out);
  wire bad = (is_call && stack_ptr_out) || (is_ret && !stack_ptr_out);
  wire hit = take && (k == psc_pkg::PSC_OP_BRANCH_UNCONDITIONAL || (k == psc_pkg::PSC_OP_BRANCH_IF_CARRY_SET && carry_in)
    || (k == psc_pkg::PSC_OP_BRANCH_IF_CARRY_CLEAR && !carry_in) || (k == psc_pkg::PSC_OP_BRANCH_IF_FLAG_SET && flag_in)
    || (k == psc_pkg::PSC_OP_BRANCH_IF_FLAG_CLEAR && !flag_in));
  wire adv = take && !hit && !is_call && !is_ret;
  wire rd15 = dm_valid_in && dm_ready_out && dm_req_in.addr == psc_pkg::PSC_SHARED_WORD;
  logic [9:0] ret_reg;

  // saved address copy; not reset, the hardware keeps it across reset
  always_ff @(posedge clk_in) begin
    if (is_call && !stack_ptr_out && !rst_in) begin
      ret_reg <= pc_out + 10'(op_in.length);
    end else if (rd15 && dm_req_in.write) begin
      ret_reg[7:0] <= dm_req_in.wdata;
    end
  end

  property p_adv;
    @(posedge clk_in) disable iff (rst_in) adv |=> pc_out == $past(pc_out) + 10'($past(op_in.length));
  endproperty
  a_adv: assert property (p_adv) else $error("pc did not advance");
  property p_branch;
    @(posedge clk_in) disable iff (rst_in) hit |=> pc_out == $past(op_in.target);
  endproperty
  a_branch: assert property (p_branch) else $error("branch target missed");
  property p_call;
    @(posedge clk_in) disable iff (rst_in) is_call && !stack_ptr_out |=> pc_out == $past(op_in.target) && stack_ptr_out;
  endproperty
  a_call: assert property (p_call) else $error("call wrong");
  property p_ret;
    @(posedge clk_in) disable iff (rst_in)
    is_ret && stack_ptr_out |=> !stack_ptr_out && !op_ready_out ##1 pc_out == ret_reg && op_ready_out;
  endproperty
  a_ret: assert property (p_ret) else $error("return wrong");
  property p_fault;
    @(posedge clk_in) disable iff (rst_in)
    bad |=> sys_reset_out && pc_out == 10'h000 && !stack_ptr_out && !op_ready_out ##1 !sys_reset_out;
  endproperty
  a_fault: assert property (p_fault) else $error("stack fault not handled");
  property p_pulse;
    @(posedge clk_in) disable iff (rst_in) $rose(sys_reset_out) |-> $past(bad);
  endproperty
  a_pulse: assert property (p_pulse) else $error("spurious system reset");
  property p_sp_hold;
    @(posedge clk_in) disable iff (rst_in) !(is_call || is_ret) |=> $stable(stack_ptr_out);
  endproperty
  a_sp_hold: assert property (p_sp_hold) else $error("stack pointer moved");
  property p_reset;
    @(posedge clk_in) disable iff (rst_in) $fell(rst_in) |-> pc_out == 10'h000 && !stack_ptr_out && !sys_reset_out;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_busy;
    @(posedge clk_in) disable iff (rst_in) good |-> !dm_ready_out;
  endproperty
  a_busy: assert property (p_busy) else $error("memory not reserved");
  property p_shared;
    @(posedge clk_in) disable iff (rst_in) rd15 && !dm_req_in.write |=> dm_rvalid_out && dm_rdata_out == ret_reg[7:0];
  endproperty
  a_shared: assert property (p_shared) else $error("shared word wrong");
endmodule : psc_sequencer_monitor

bind psc_sequencer psc_sequencer_monitor u_mon (.clk_in(clk_in), .rst_in(rst_in), .op_valid_in(op_valid_in),
  .op_in(op_in), .carry_in(carry_in), .flag_in(flag_in), .op_ready_out(op_ready_out), .pc_out(pc_out),
  .stack_ptr_out(stack_ptr_out), .sys_reset_out(sys_reset_out), .dm_valid_in(dm_valid_in), .dm_req_in(dm_req_in),
  .dm_ready_out(dm_ready_out), .dm_rdata_out(dm_rdata_out), .dm_rvalid_out(dm_rvalid_out));

// *** tb/psc_sequencer_bench.sv ***
// self-checking bench of the program sequencer with a reference model
`timescale 1ns/100ps

module psc_sequencer_bench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic op_valid_in = 1'b0;
  psc_pkg::psc_op_type op_in = '0;
  logic carry_in = 1'b0;
  logic flag_in = 1'b0;
  logic dm_valid_in = 1'b0;
  psc_pkg::psc_dm_req_type dm_req_in = '0;
  logic op_ready_out, stack_ptr_out, sys_reset_out, dm_ready_out, dm_rvalid_out;
  logic [9:0] pc_out;
  logic [7:0] dm_rdata_out;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int pc_m = 0;
  int sp_m = 0;
  int ret_m = 0;
  int mem_m [16];
  logic [31:0] seed_reg = 32'hc495;

  psc_sequencer dut (.clk_in(clk_in), .rst_in(rst_in), .op_valid_in(op_valid_in), .op_in(op_in),
    .carry_in(carry_in), .flag_in(flag_in), .op_ready_out(op_ready_out), .pc_out(pc_out),
    .stack_ptr_out(stack_ptr_out), .sys_reset_out(sys_reset_out), .dm_valid_in(dm_valid_in),
    .dm_req_in(dm_req_in), .dm_ready_out(dm_ready_out), .dm_rdata_out(dm_rdata_out), .dm_rvalid_out(dm_rvalid_out));

  // 25 MHz clock
  initial begin
    forever #20 clk_in = ~clk_in;
  end

  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed_reg = seed_reg ^ (seed_reg << 13);
    seed_reg = seed_reg ^ (seed_reg >> 17);
    seed_reg = seed_reg ^ (seed_reg << 5);
    return seed_reg;
  endfunction : rnd

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // hang guard, far above the several hundred cycles the run needs
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fails++;
      finish_test();
    end
  end

  // ready is sampled mid-cycle so the request holds until the taking edge
  task automatic wait_take(input logic is_op);
    logic rdy;
    do begin
      @(negedge clk_in);
      rdy = is_op ? op_ready_out : dm_ready_out;
      @(posedge clk_in);
    end while (rdy !== 1'b1);
  endtask : wait_take

  task automatic do_op(input int k, input int l, input int t, input logic c, input logic f);
    bit hit;
    bit bad;
    @(posedge clk_in);
    op_valid_in <= 1'b1;
    op_in <= '{psc_pkg::psc_kind_type'(k), 2'(l), 10'(t)};
    carry_in <= c;
    flag_in <= f;
    wait_take(1'b1);
    op_valid_in <= 1'b0;
    hit = k == 1 || (k == 2 && c) || (k == 3 && !c) || (k == 4 && f) || (k == 5 && !f);
    bad = (k == 6 && sp_m == 1) || (k == 7 && sp_m == 0);
    if (bad) begin
      pc_m = 0;
      sp_m = 0;
    end else if (k == 6) begin
      ret_m = (pc_m + l) % 1024;
      mem_m[15] = ret_m % 256;
      sp_m = 1;
      pc_m = t;
    end else if (k == 7) begin
      sp_m = 0;
      pc_m = ret_m;
    end else begin
      pc_m = hit ? t : (pc_m + l) % 1024;
    end
    @(negedge clk_in);
    chk({31'h0, sys_reset_out}, 32'(bad));
    chk({31'h0, stack_ptr_out}, 32'(sp_m));
    if (k == 7 && !bad) begin
      chk({31'h0, op_ready_out}, 32'h0);
      @(negedge clk_in);
    end
    chk({22'h0, pc_out}, 32'(pc_m));
  endtask : do_op

  task automatic dm_acc(input logic w, input int a, input int d);
    @(posedge clk_in);
    dm_valid_in <= 1'b1;
    dm_req_in <= '{w, 4'(a), 8'(d)};
    wait_take(1'b0);
    dm_valid_in <= 1'b0;
    if (w) begin
      mem_m[a] = d;
      ret_m = a == 15 ? ret_m / 256 * 256 + d : ret_m;
    end else begin
      @(negedge clk_in);
      chk({31'h0, dm_rvalid_out}, 32'h1);
      chk({24'h0, dm_rdata_out}, 32'(mem_m[a]));
    end
  endtask : dm_acc

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    chk({22'h0, pc_out}, 32'h0);
    chk({31'h0, stack_ptr_out}, 32'h0);
    for (int i = 0; i < 32; i++) begin
      dm_acc(i < 16, i % 16, rnd() % 256);
    end
    // jump high so the call saves upper bits, data write over the saved byte,
    // then exit, then a double call and a bare exit
    do_op(1, 0, 10'h2fe, 1'b0, 1'b0);
    do_op(6, 1, 10'h155, 1'b0, 1'b0);
    dm_acc(1'b1, 15, 8'h5a);
    do_op(7, 0, 0, 1'b0, 1'b0);
    dm_acc(1'b0, 15, 0);
    do_op(6, 2, 10'h2aa, 1'b0, 1'b0);
    do_op(6, 1, 0, 1'b0, 1'b0);
    do_op(7, 1, 0, 1'b0, 1'b0);
    // call contends with a data read of the shared word
    fork
      do_op(6, 3, 10'h3ff, 1'b0, 1'b0);
      dm_acc(1'b0, 15, 0);
    join
    // reset in mid-call keeps the saved byte
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    pc_m = 0;
    sp_m = 0;
    @(negedge clk_in);
    chk({31'h0, stack_ptr_out}, 32'h0);
    dm_acc(1'b0, 15, 0);
    for (int i = 0; i < 80; i++) begin
      do_op(rnd() % 8, rnd() % 4, rnd() % 1024, rnd() % 2, rnd() % 2);
      dm_acc(1'b0, rnd() % 15, 0);
    end
    finish_test();
  end
endmodule : psc_sequencer_bench
